//--- crossbar_pkg.sv
/*
  Shared constants and carrier types for the port crossbar block.
  Assumes an 8-bit special function register bus and a single system clock.
*/
package crossbar_pkg;

  localparam int NUM_PORTS = 4;
  localparam int NUM_PINS = 25;
  localparam int NUM_XBAR_PINS = 20;
  localparam int NUM_FUNCS = 20;

  // Register addresses
  localparam logic [7:0] ADDR_PORT_ZERO_LATCH = 8'h80;
  localparam logic [7:0] ADDR_PORT_ONE_LATCH = 8'h90;
  localparam logic [7:0] ADDR_PORT_TWO_LATCH = 8'hA0;
  localparam logic [7:0] ADDR_PORT_THREE_LATCH = 8'hB0;
  localparam logic [7:0] ADDR_DRIVER_KIND_BASE = 8'hA4;
  localparam logic [7:0] ADDR_SKIP_BASE = 8'hD4;
  localparam logic [7:0] ADDR_ROUTE_PRIMARY = 8'hE1;
  localparam logic [7:0] ADDR_ROUTE_SECONDARY = 8'hE2;
  localparam logic [7:0] ADDR_PORT_ZERO_INPUT_KIND = 8'hF1;
  localparam logic [7:0] ADDR_PORT_ONE_INPUT_KIND = 8'hF2;
  localparam logic [7:0] ADDR_PORT_TWO_INPUT_KIND = 8'hE3;
  localparam logic [7:0] ADDR_PORT_THREE_INPUT_KIND = 8'hF4;
  localparam logic [7:0] ADDR_PORT_THREE_DRIVER_KIND = 8'hA7;

  // Reset values and port bit masks
  localparam logic [7:0] RESET_LATCH = 8'hFF;
  localparam logic [7:0] RESET_INPUT_KIND = 8'hFF;
  localparam logic [7:0] RESET_DRIVER_KIND = 8'h00;
  localparam logic [7:0] RESET_SKIP = 8'h00;
  localparam logic [7:0] RESET_ROUTE = 8'h00;
  localparam logic [7:0] PORT_TWO_SKIP_MASK = 8'h0F;
  localparam logic [7:0] PORT_THREE_MASK = 8'h01;

  // Primary route register fields
  localparam int BIT_ASYNC_SERIAL_ROUTE = 0;
  localparam int BIT_SERIAL_PERIPH_ROUTE = 1;
  localparam int BIT_TWOWIRE_BUS_ROUTE = 2;
  localparam int BIT_SYS_CLOCK_OUT_ROUTE = 3;
  localparam int BIT_COMPARATOR_ZERO_ROUTE = 4;
  localparam int BIT_COMPARATOR_ZERO_ASYNC_ROUTE = 5;
  localparam int BIT_COMPARATOR_ONE_ROUTE = 6;
  localparam int BIT_COMPARATOR_ONE_ASYNC_ROUTE = 7;

  // Secondary route register fields
  localparam int BIT_PULLUP_DISABLE = 7;
  localparam int BIT_CROSSBAR_ENABLE = 6;
  localparam int BIT_TIMER_ONE_INPUT_ROUTE = 5;
  localparam int BIT_TIMER_ZERO_INPUT_ROUTE = 4;
  localparam int BIT_COUNTER_ARRAY_COUNT_ROUTE = 3;
  localparam int MODULE_COUNT_MSB = 2;
  localparam logic [2:0] MODULE_COUNT_MAX = 3'b101;
  localparam int NUM_COUNTER_MODULES = 5;

  // Fixed pins of the asynchronous serial unit
  localparam int PIN_ASYNC_SERIAL_TRANSMIT = 4;
  localparam int PIN_ASYNC_SERIAL_RECEIVE = 5;

  // Function codes, in priority order; 0 means plain port pin
  localparam logic [4:0] FN_NONE = 5'h00;
  localparam logic [4:0] FN_ASYNC_SERIAL_TRANSMIT = 5'h01;
  localparam logic [4:0] FN_ASYNC_SERIAL_RECEIVE = 5'h02;
  localparam logic [4:0] FN_SPI_CLOCK = 5'h03;
  localparam logic [4:0] FN_SPI_MISO = 5'h04;
  localparam logic [4:0] FN_SPI_MOSI = 5'h05;
  localparam logic [4:0] FN_SLAVE_SELECT = 5'h06;
  localparam logic [4:0] FN_TWOWIRE_DATA = 5'h07;
  localparam logic [4:0] FN_TWOWIRE_CLOCK = 5'h08;
  localparam logic [4:0] FN_SYS_CLOCK_OUT = 5'h09;
  localparam logic [4:0] FN_COMPARATOR_ZERO = 5'h0A;
  localparam logic [4:0] FN_COMPARATOR_ZERO_ASYNC = 5'h0B;
  localparam logic [4:0] FN_COMPARATOR_ONE = 5'h0C;
  localparam logic [4:0] FN_COMPARATOR_ONE_ASYNC = 5'h0D;
  localparam logic [4:0] FN_MODULE_IO_FIRST = 5'h0E;
  localparam logic [4:0] FN_COUNT_INPUT = 5'h13;
  localparam logic [4:0] FN_TIMER_ZERO_INPUT = 5'h14;
  localparam logic [4:0] FN_TIMER_ONE_INPUT = 5'h15;
  localparam int FN_LAST = 21;

  // Per-function signals, indexed by function code
  typedef struct packed {
    logic [FN_LAST:0] value;
    logic [FN_LAST:0] drive;
  } periph_out_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic rmw;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic [NUM_PINS-1:0] level;
    logic [NUM_PINS-1:0] drive_en;
    logic [NUM_PINS-1:0] pullup_en;
  } pin_drive_t;

endpackage

//--- priority_crossbar_port_io.sv
/*
  Port I/O block with priority crossbar, port latches and pin configuration.
  Assumes the CPU presents synchronous special function register accesses,
  with rmw high on reads belonging to read-modify-write or bit instructions,
  and that peripherals present one value and drive request per function.
*/
// What this block does
// RL1 - Each enabled function takes lowest free pin
// RL2 - Serial transmit and receive fixed to P0.4/P0.5
// RL3 - Skipped pins count as already taken
// RL4 - Two-wire and serial pairs assigned together
// RL5 - Leftover pins stay plain port pins
// RL6 - Slave select routed only in four-wire mode
// RL7 - Analog pins: no pull-up, driver, receiver
// RL8 - Input kind bits reset to ones
// RL9 - Driver kind picks open-drain or push-pull
// RL10 - Pull-up disable bit gates open-drain pull-ups
// RL11 - Pull-up off while pin drives low
// RL12 - Crossbar off disables drivers up to P2.3
// RL13 - Primary route register enables functions 1 to 13
// RL14 - Secondary register routes timers and count input
// RL15 - Module count field routes first N modules
// RL16 - Write latches data, read returns pin levels
// RL17 - Read-modify-write reads latch, not pins
// RL18 - Latches reset to ones, one means release
// RL19 - Software configures before enabling crossbar
// RL20 - Software skips pins used outside crossbar
// RL21 - Digital input needs open-drain and latch one
// RL22 - Only P0.0 to P2.3 take routed functions
// RL23 - Assumed priority order after fixed serial pair
`timescale 1ns/1ps

module priority_crossbar_port_io (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register bus
  input wire crossbar_pkg::sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // Peripherals
  input wire crossbar_pkg::periph_out_t periph_out,
  input wire logic spi_four_wire,
  output logic [crossbar_pkg::FN_LAST:0] periph_in,
  // Pins
  input wire logic [crossbar_pkg::NUM_PINS-1:0] pin_i,
  output crossbar_pkg::pin_drive_t pin_out
);

  logic [7:0] latch_reg [crossbar_pkg::NUM_PORTS];
  logic [7:0] input_kind_reg [crossbar_pkg::NUM_PORTS];
  logic [7:0] driver_kind_reg [crossbar_pkg::NUM_PORTS];
  logic [7:0] skip_reg [crossbar_pkg::NUM_PORTS];
  logic [7:0] route_enable_primary;
  logic [7:0] route_enable_secondary;

  logic [crossbar_pkg::NUM_PINS-1:0] latch_flat;
  logic [crossbar_pkg::NUM_PINS-1:0] input_kind_flat;
  logic [crossbar_pkg::NUM_PINS-1:0] driver_kind_flat;
  logic [crossbar_pkg::NUM_XBAR_PINS-1:0] skip_flat;
  logic [crossbar_pkg::FN_LAST:0] func_en;
  logic [4:0] pin_func [crossbar_pkg::NUM_XBAR_PINS];
  logic pullup_disable;
  logic crossbar_enable;

  // Register kinds reached over the bus
  typedef enum logic [2:0] {
    REG_NONE, REG_LATCH, REG_INPUT_KIND, REG_DRIVER_KIND, REG_SKIP, REG_ROUTE_PRIMARY, REG_ROUTE_SECONDARY
  } reg_kind_t;

  typedef struct packed {
    reg_kind_t kind;
    logic [1:0] port;
  } reg_sel_t;

  function automatic reg_sel_t decode(input logic [7:0] addr);
    reg_sel_t sel;
    sel = '{kind: REG_NONE, port: 2'd0};
    unique case (addr)
      crossbar_pkg::ADDR_PORT_ZERO_LATCH: sel = '{kind: REG_LATCH, port: 2'd0};
      crossbar_pkg::ADDR_PORT_ONE_LATCH: sel = '{kind: REG_LATCH, port: 2'd1};
      crossbar_pkg::ADDR_PORT_TWO_LATCH: sel = '{kind: REG_LATCH, port: 2'd2};
      crossbar_pkg::ADDR_PORT_THREE_LATCH: sel = '{kind: REG_LATCH, port: 2'd3};
      crossbar_pkg::ADDR_PORT_ZERO_INPUT_KIND: sel = '{kind: REG_INPUT_KIND, port: 2'd0};
      crossbar_pkg::ADDR_PORT_ONE_INPUT_KIND: sel = '{kind: REG_INPUT_KIND, port: 2'd1};
      crossbar_pkg::ADDR_PORT_TWO_INPUT_KIND: sel = '{kind: REG_INPUT_KIND, port: 2'd2};
      crossbar_pkg::ADDR_PORT_THREE_INPUT_KIND: sel = '{kind: REG_INPUT_KIND, port: 2'd3};
      crossbar_pkg::ADDR_DRIVER_KIND_BASE: sel = '{kind: REG_DRIVER_KIND, port: 2'd0};
      crossbar_pkg::ADDR_DRIVER_KIND_BASE + 8'h01: sel = '{kind: REG_DRIVER_KIND, port: 2'd1};
      crossbar_pkg::ADDR_DRIVER_KIND_BASE + 8'h02: sel = '{kind: REG_DRIVER_KIND, port: 2'd2};
      crossbar_pkg::ADDR_PORT_THREE_DRIVER_KIND: sel = '{kind: REG_DRIVER_KIND, port: 2'd3};
      crossbar_pkg::ADDR_SKIP_BASE: sel = '{kind: REG_SKIP, port: 2'd0};
      crossbar_pkg::ADDR_SKIP_BASE + 8'h01: sel = '{kind: REG_SKIP, port: 2'd1};
      crossbar_pkg::ADDR_SKIP_BASE + 8'h02: sel = '{kind: REG_SKIP, port: 2'd2};
      crossbar_pkg::ADDR_ROUTE_PRIMARY: sel = '{kind: REG_ROUTE_PRIMARY, port: 2'd0};
      crossbar_pkg::ADDR_ROUTE_SECONDARY: sel = '{kind: REG_ROUTE_SECONDARY, port: 2'd0};
      default: sel = '{kind: REG_NONE, port: 2'd0};
    endcase
    return sel;
  endfunction

  // Bits that exist in each port register; port 3 has only its first pin
  function automatic logic [7:0] port_mask(input logic [1:0] port, input reg_kind_t kind);
    logic [7:0] m;
    m = 8'hFF;
    if (port == 2'd3) begin
      m = crossbar_pkg::PORT_THREE_MASK;
    end else if (port == 2'd2 && kind == REG_SKIP) begin
      m = crossbar_pkg::PORT_TWO_SKIP_MASK;
    end
    return m;
  endfunction

  reg_sel_t wr_sel;
  reg_sel_t rd_sel;
  assign wr_sel = decode(sfr_req.addr);
  assign rd_sel = wr_sel;

  // Configuration registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < crossbar_pkg::NUM_PORTS; i++) begin
        latch_reg[i] <= crossbar_pkg::RESET_LATCH; // RL18
        input_kind_reg[i] <= crossbar_pkg::RESET_INPUT_KIND; // RL8
        driver_kind_reg[i] <= crossbar_pkg::RESET_DRIVER_KIND;
        skip_reg[i] <= crossbar_pkg::RESET_SKIP;
      end
      route_enable_primary <= crossbar_pkg::RESET_ROUTE;
      route_enable_secondary <= crossbar_pkg::RESET_ROUTE;
    end else if (sfr_req.wr) begin
      unique case (wr_sel.kind)
        REG_LATCH: latch_reg[wr_sel.port] <= sfr_req.wdata; // RL16
        REG_INPUT_KIND: input_kind_reg[wr_sel.port] <= sfr_req.wdata;
        REG_DRIVER_KIND: driver_kind_reg[wr_sel.port] <= sfr_req.wdata;
        REG_SKIP: skip_reg[wr_sel.port] <= sfr_req.wdata & port_mask(wr_sel.port, REG_SKIP);
        REG_ROUTE_PRIMARY: route_enable_primary <= sfr_req.wdata; // RL13
        REG_ROUTE_SECONDARY: route_enable_secondary <= sfr_req.wdata; // RL14
        // Unmapped addresses land here and change nothing
        REG_NONE: ;
      endcase
    end
  end

  // Read port: plain reads see the pins, read-modify-write reads see the latch
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_req.rd) begin
      unique case (rd_sel.kind)
        REG_LATCH: begin
          if (sfr_req.rmw) begin
            sfr_rdata <= latch_reg[rd_sel.port] & port_mask(rd_sel.port, REG_LATCH); // RL17
          end else begin
            // RL16 RL7
            sfr_rdata <= port_pins(rd_sel.port) & input_kind_reg[rd_sel.port] & port_mask(rd_sel.port, REG_LATCH);
          end
        end
        REG_INPUT_KIND: sfr_rdata <= input_kind_reg[rd_sel.port] & port_mask(rd_sel.port, REG_INPUT_KIND);
        REG_DRIVER_KIND: sfr_rdata <= driver_kind_reg[rd_sel.port] & port_mask(rd_sel.port, REG_DRIVER_KIND);
        REG_SKIP: sfr_rdata <= skip_reg[rd_sel.port];
        REG_ROUTE_PRIMARY: sfr_rdata <= route_enable_primary;
        REG_ROUTE_SECONDARY: sfr_rdata <= route_enable_secondary;
        // Unmapped addresses read as zero
        REG_NONE: sfr_rdata <= 8'h00;
      endcase
    end
  end

  // Live pin levels of one port; missing pins read zero
  function automatic logic [7:0] port_pins(input logic [1:0] port);
    logic [7:0] v;
    v = 8'h00;
    unique case (port)
      2'd0: v = pin_i[7:0];
      2'd1: v = pin_i[15:8];
      2'd2: v = pin_i[23:16];
      2'd3: v = {7'd0, pin_i[24]};
    endcase
    return v;
  endfunction

  // Port 3 has one pin and port 2 skips only its low nibble
  always_comb begin
    latch_flat = {latch_reg[3][0], latch_reg[2], latch_reg[1], latch_reg[0]};
    input_kind_flat = {input_kind_reg[3][0], input_kind_reg[2], input_kind_reg[1], input_kind_reg[0]};
    driver_kind_flat = {driver_kind_reg[3][0], driver_kind_reg[2], driver_kind_reg[1], driver_kind_reg[0]};
    skip_flat = {skip_reg[2][3:0], skip_reg[1], skip_reg[0]};
  end

  assign pullup_disable = route_enable_secondary[crossbar_pkg::BIT_PULLUP_DISABLE];
  assign crossbar_enable = route_enable_secondary[crossbar_pkg::BIT_CROSSBAR_ENABLE];

  // Enabled functions, listed in priority order
  always_comb begin
    logic [2:0] mods;
    mods = route_enable_secondary[crossbar_pkg::MODULE_COUNT_MSB:0];
    func_en = '0;
    func_en[crossbar_pkg::FN_SPI_CLOCK] = route_enable_primary[crossbar_pkg::BIT_SERIAL_PERIPH_ROUTE]; // RL23
    func_en[crossbar_pkg::FN_SPI_MISO] = route_enable_primary[crossbar_pkg::BIT_SERIAL_PERIPH_ROUTE];
    func_en[crossbar_pkg::FN_SPI_MOSI] = route_enable_primary[crossbar_pkg::BIT_SERIAL_PERIPH_ROUTE];
    // In three-wire mode the slave select takes no pin, so later functions move up
    func_en[crossbar_pkg::FN_SLAVE_SELECT] =
      route_enable_primary[crossbar_pkg::BIT_SERIAL_PERIPH_ROUTE] & spi_four_wire; // RL6
    func_en[crossbar_pkg::FN_TWOWIRE_DATA] = route_enable_primary[crossbar_pkg::BIT_TWOWIRE_BUS_ROUTE]; // RL4
    func_en[crossbar_pkg::FN_TWOWIRE_CLOCK] = route_enable_primary[crossbar_pkg::BIT_TWOWIRE_BUS_ROUTE]; // RL4
    func_en[crossbar_pkg::FN_SYS_CLOCK_OUT] = route_enable_primary[crossbar_pkg::BIT_SYS_CLOCK_OUT_ROUTE];
    func_en[crossbar_pkg::FN_COMPARATOR_ZERO] = route_enable_primary[crossbar_pkg::BIT_COMPARATOR_ZERO_ROUTE];
    func_en[crossbar_pkg::FN_COMPARATOR_ZERO_ASYNC] =
      route_enable_primary[crossbar_pkg::BIT_COMPARATOR_ZERO_ASYNC_ROUTE];
    func_en[crossbar_pkg::FN_COMPARATOR_ONE] = route_enable_primary[crossbar_pkg::BIT_COMPARATOR_ONE_ROUTE];
    func_en[crossbar_pkg::FN_COMPARATOR_ONE_ASYNC] =
      route_enable_primary[crossbar_pkg::BIT_COMPARATOR_ONE_ASYNC_ROUTE];
    // Reserved module counts route nothing
    for (int m = 0; m < crossbar_pkg::NUM_COUNTER_MODULES; m++) begin
      func_en[crossbar_pkg::FN_MODULE_IO_FIRST + m] = (mods <= crossbar_pkg::MODULE_COUNT_MAX) && (m < mods); // RL15
    end
    func_en[crossbar_pkg::FN_COUNT_INPUT] = route_enable_secondary[crossbar_pkg::BIT_COUNTER_ARRAY_COUNT_ROUTE];
    func_en[crossbar_pkg::FN_TIMER_ZERO_INPUT] = route_enable_secondary[crossbar_pkg::BIT_TIMER_ZERO_INPUT_ROUTE];
    func_en[crossbar_pkg::FN_TIMER_ONE_INPUT] = route_enable_secondary[crossbar_pkg::BIT_TIMER_ONE_INPUT_ROUTE];
  end

  // Priority decoder: walk pins upward, handing each free pin the next enabled function
  always_comb begin
    int next_fn;
    logic found;
    logic uart_on;
    next_fn = crossbar_pkg::FN_SPI_CLOCK;
    found = 1'b0;
    uart_on = route_enable_primary[crossbar_pkg::BIT_ASYNC_SERIAL_ROUTE];
    for (int p = 0; p < crossbar_pkg::NUM_XBAR_PINS; p++) begin // RL22
      pin_func[p] = crossbar_pkg::FN_NONE; // RL5
      found = 1'b0;
      // The serial pair is fixed, so it ignores skips and never advances the walk
      if (uart_on && p == crossbar_pkg::PIN_ASYNC_SERIAL_TRANSMIT) begin
        pin_func[p] = crossbar_pkg::FN_ASYNC_SERIAL_TRANSMIT; // RL2 RL4
      end else if (uart_on && p == crossbar_pkg::PIN_ASYNC_SERIAL_RECEIVE) begin
        pin_func[p] = crossbar_pkg::FN_ASYNC_SERIAL_RECEIVE; // RL2 RL4
      end else if (!skip_flat[p]) begin // RL3
        for (int f = crossbar_pkg::FN_SPI_CLOCK; f <= crossbar_pkg::FN_LAST; f++) begin
          if (!found && f >= next_fn && func_en[f]) begin
            pin_func[p] = 5'(f); // RL1
            found = 1'b1;
          end
        end
        if (found) begin
          next_fn = int'(pin_func[p]) + 1;
        end
      end
    end
  end

  // Pin drive, registered so every pin output comes from a flip-flop
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pin_out <= '0;
    end else begin
      for (int p = 0; p < crossbar_pkg::NUM_PINS; p++) begin
        logic [4:0] f;
        logic val;
        logic want;
        logic open_drain;
        logic drv;
        f = (p < crossbar_pkg::NUM_XBAR_PINS) ? pin_func[p] : crossbar_pkg::FN_NONE;
        val = (f == crossbar_pkg::FN_NONE) ? latch_flat[p] : periph_out.value[f];
        want = (f == crossbar_pkg::FN_NONE) ? 1'b1 : periph_out.drive[f];
        open_drain = !driver_kind_flat[p] || f == crossbar_pkg::FN_TWOWIRE_DATA
          || f == crossbar_pkg::FN_TWOWIRE_CLOCK; // RL9
        // Open-drain only ever pulls low; a one is left to the pull-up
        drv = input_kind_flat[p] && want && (!open_drain || !val) // RL7 RL18
          && (crossbar_enable || p >= crossbar_pkg::NUM_XBAR_PINS); // RL12
        pin_out.level[p] <= val;
        pin_out.drive_en[p] <= drv;
        // Drop the pull-up while the pin sinks, it would only burn current
        pin_out.pullup_en[p] <= input_kind_flat[p] && open_drain && !pullup_disable // RL10
          && !(drv && !val); // RL11
      end
    end
  end

  // Peripheral inputs see their assigned pin; an unrouted or analog input idles high
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      periph_in <= '1;
    end else begin
      for (int f = 0; f <= crossbar_pkg::FN_LAST; f++) begin
        logic hit;
        logic lvl;
        hit = 1'b0;
        lvl = 1'b1;
        // Only crossbar pins can carry a routed input
        for (int p = 0; p < crossbar_pkg::NUM_XBAR_PINS; p++) begin
          if (!hit && f != 0 && int'(pin_func[p]) == f && crossbar_enable) begin
            hit = 1'b1;
            lvl = pin_i[p] | !input_kind_flat[p]; // RL7
          end
        end
        periph_in[f] <= lvl;
      end
    end
  end

endmodule

//--- crossbar_properties.sv
/*
  Checker for the port crossbar block, bound to its top module.
  Assumes one clock, active-low reset and shadows only of the port zero and route registers.
*/
`timescale 1ns/1ps

module crossbar_properties (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register bus
  input wire crossbar_pkg::sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  // Peripherals
  input wire crossbar_pkg::periph_out_t periph_out,
  input wire logic spi_four_wire,
  input wire logic [crossbar_pkg::FN_LAST:0] periph_in,
  // Pins
  input wire logic [crossbar_pkg::NUM_PINS-1:0] pin_i,
  input wire crossbar_pkg::pin_drive_t pin_out
);
  logic [7:0] latch_reg, kind_reg, drv_reg, route0_reg, route1_reg;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  // Shadows let the checks work without any view of the body
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      latch_reg <= 8'hFF;
      kind_reg <= 8'hFF;
      drv_reg <= 8'h00;
      route0_reg <= 8'h00;
      route1_reg <= 8'h00;
    end else if (sfr_req.wr) begin
      case (sfr_req.addr)
        8'h80: latch_reg <= sfr_req.wdata;
        8'hF1: kind_reg <= sfr_req.wdata;
        8'hA4: drv_reg <= sfr_req.wdata;
        8'hE1: route0_reg <= sfr_req.wdata;
        8'hE2: route1_reg <= sfr_req.wdata;
        default: ;
      endcase
    end
  end

  rmw_latch_a: assert property (
    sfr_req.rd && sfr_req.rmw && sfr_req.addr == 8'h80 |=> sfr_rdata == $past(latch_reg))
    else $error("rmw read did not return the latch");
  pin_read_a: assert property (
    sfr_req.rd && !sfr_req.rmw && sfr_req.addr == 8'h80 |=> sfr_rdata == ($past(pin_i[7:0]) & $past(kind_reg)))
    else $error("plain read did not return the pins");
  analog_pin_a: assert property (
    ((pin_out.drive_en[7:0] | pin_out.pullup_en[7:0]) & ~$past(kind_reg)) == 8'h00)
    else $error("analog pin drives or pulls up");
  pullup_low_a: assert property (
    (pin_out.pullup_en & pin_out.drive_en & ~pin_out.level) == '0)
    else $error("pull-up on while driving low");
  pullup_off_a: assert property (
    $past(route1_reg[7]) |-> pin_out.pullup_en == '0)
    else $error("pull-up on while disabled");
  crossbar_off_a: assert property (
    !$past(route1_reg[6]) |-> pin_out.drive_en[19:0] == '0)
    else $error("driver on while crossbar off");
  open_drain_a: assert property (
    (pin_out.drive_en[7:0] & pin_out.level[7:0] & ~$past(drv_reg)) == 8'h00)
    else $error("open-drain pin driven high");
  uart_fixed_a: assert property (
    $past(route0_reg[0] && route1_reg[6] && kind_reg[4] && periph_out.drive[1] && !periph_out.value[1])
    |-> pin_out.drive_en[4] && !pin_out.level[4])
    else $error("serial transmit not on pin four");
endmodule

bind priority_crossbar_port_io crossbar_properties chk (
  .mclk(mclk), .rstn(rstn), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .periph_out(periph_out),
  .spi_four_wire(spi_four_wire), .periph_in(periph_in), .pin_i(pin_i), .pin_out(pin_out)
);

//--- pin_world.sv
/*
  Model of the board around the pins: drivers, pull-ups and outside pull-downs.
  Assumes the block's pin_out record; undriven pins with no pull toggle each cycle.
*/
`timescale 1ns/1ps

module pin_world (
  // Clock
  input wire logic mclk,
  // Block drivers and outside pull-downs
  input wire crossbar_pkg::pin_drive_t pin_out,
  input wire logic [24:0] ext_low,
  // Resolved levels
  output logic [24:0] pin_i
);
  logic [24:0] float_reg = '0;

  // A floating pin must not look like a stable level
  always_ff @(posedge mclk) begin
    float_reg <= ~float_reg;
  end

  assign pin_i = (pin_out.drive_en & pin_out.level)
    | (~pin_out.drive_en & ~ext_low & (pin_out.pullup_en | float_reg));
endmodule

//--- priority_crossbar_port_io_bench.sv
/*
  Self-checking bench for the port crossbar block: route table, then port tests.
  Assumes pin_world and the bound checker are compiled with the design.
*/
`timescale 1ns/1ps

module priority_crossbar_port_io_bench;
  typedef struct {
    logic [7:0] x0;
    logic [7:0] x1;
    logic [7:0] sk;
    logic fw;
    logic [4:0] fn;
    int pin;
    logic out;
  } row_t;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  crossbar_pkg::sfr_req_t sfr_req = '0;
  crossbar_pkg::periph_out_t periph_out = '0;
  logic spi_four_wire = 1'b1;
  logic [24:0] ext_low = '0;
  logic [7:0] sfr_rdata;
  logic [crossbar_pkg::FN_LAST:0] periph_in;
  logic [24:0] pin_i;
  crossbar_pkg::pin_drive_t pin_out;
  int err_total = 0;
  int checks = 0;
  row_t r;
  // Route enables, secondary, skip, four-wire, function, pin, drives
  row_t rows [16] = '{
    '{8'h01, 8'h40, 8'h00, 1'b1, 5'h01, 4, 1'b1},
    '{8'h01, 8'h40, 8'h00, 1'b1, 5'h02, 5, 1'b0},
    '{8'h02, 8'h40, 8'h00, 1'b1, 5'h03, 0, 1'b1},
    '{8'h02, 8'h40, 8'h00, 1'b1, 5'h04, 1, 1'b0},
    '{8'h02, 8'h40, 8'h00, 1'b1, 5'h06, 3, 1'b1},
    '{8'h0A, 8'h40, 8'h00, 1'b0, 5'h09, 3, 1'b1},
    '{8'h03, 8'h40, 8'h03, 1'b1, 5'h05, 6, 1'b1},
    '{8'h03, 8'h40, 8'h03, 1'b1, 5'h06, 7, 1'b1},
    '{8'h04, 8'h40, 8'h00, 1'b1, 5'h08, 1, 1'b1},
    '{8'hF9, 8'h40, 8'h00, 1'b1, 5'h0D, 6, 1'b1},
    '{8'hF0, 8'h40, 8'h00, 1'b1, 5'h0B, 1, 1'b1},
    '{8'h00, 8'h7D, 8'h00, 1'b1, 5'h12, 4, 1'b1},
    '{8'h00, 8'h7D, 8'h00, 1'b1, 5'h15, 7, 1'b0},
    '{8'h00, 8'h50, 8'h00, 1'b1, 5'h14, 0, 1'b0},
    '{8'h00, 8'h4E, 8'h00, 1'b1, 5'h13, 0, 1'b0},
    '{8'h02, 8'h40, 8'hFF, 1'b1, 5'h06, 11, 1'b1}
  };

  priority_crossbar_port_io DUT (
    .mclk(mclk), .rstn(rstn), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .periph_out(periph_out),
    .spi_four_wire(spi_four_wire), .periph_in(periph_in), .pin_i(pin_i), .pin_out(pin_out)
  );
  pin_world far (.mclk(mclk), .pin_out(pin_out), .ext_low(ext_low), .pin_i(pin_i));

  initial begin
    forever #5 mclk = ~mclk;
  end

  task automatic cmp(input string n, input logic [74:0] e, input logic [74:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr_req = '{a, 1'b1, 1'b0, 1'b0, d};
    @(negedge mclk);
    sfr_req.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] e, input string n);
    @(negedge mclk);
    sfr_req = '{a, 1'b0, 1'b1, m, 8'h00};
    @(negedge mclk);
    sfr_req.rd = 1'b0;
    cmp(n, e, sfr_rdata);
  endtask

  // Config to pin_out, then pin to periph_in: one cycle each
  task automatic settle;
    repeat (2) @(negedge mclk);
  endtask

  task automatic do_reset;
    @(negedge mclk);
    rstn = 1'b0;
    repeat (12) @(negedge mclk);
    cmp("pins in reset", '0, pin_out);
    cmp("rdata in reset", '0, sfr_rdata);
    cmp("inputs in reset", {22{1'b1}}, periph_in);
    rstn = 1'b1;
    settle();
    cmp("drive after reset", '0, pin_out.drive_en);
    cmp("pullups after reset", {25{1'b1}}, pin_out.pullup_en);
    rd(8'h80, 1'b1, 8'hFF, "latch reset");
    rd(8'hF1, 1'b0, 8'hFF, "input kind reset");
    rd(8'hE1, 1'b0, 8'h00, "primary reset");
    rd(8'hE2, 1'b0, 8'h00, "secondary reset");
    $display("test reset done");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    do_reset();
    foreach (rows[i]) begin
      r = rows[i];
      periph_out = '{value: '0, drive: 22'(r.out) << r.fn};
      ext_low = 25'(!r.out) << r.pin;
      spi_four_wire = r.fw;
      wr(8'hD4, r.sk);
      wr(8'hE1, r.x0);
      wr(8'hE2, r.x1);
      settle();
      if (r.out) cmp("routed drive", 25'h000_0001 << r.pin, pin_out.drive_en);
      cmp("routed input", 1'b0, periph_in[r.fn]);
    end
    $display("test route table done");
    periph_out = '0;
    ext_low = 25'h000_0008;
    wr(8'hE1, 8'h00);
    wr(8'hD4, 8'h00);
    wr(8'hE2, 8'h40);
    wr(8'hF1, 8'hFD);
    wr(8'h80, 8'h5A);
    settle();
    rd(8'h80, 1'b1, 8'h5A, "latch by rmw");
    rd(8'h80, 1'b0, 8'h50, "pins by read");
    cmp("open-drain pullups", 8'h58, pin_out.pullup_en[7:0]);
    cmp("open-drain drive", 8'hA5, pin_out.drive_en[7:0]);
    cmp("latch levels", 8'h5A, pin_out.level[7:0]);
    wr(8'hA4, 8'h10);
    settle();
    cmp("push-pull drive", 8'hB5, pin_out.drive_en[7:0]);
    cmp("push-pull pullups", 8'h48, pin_out.pullup_en[7:0]);
    wr(8'hE2, 8'hC0);
    settle();
    cmp("pullups disabled", '0, pin_out.pullup_en);
    $display("test port latch done");
    ext_low = '0;
    wr(8'hA4, 8'hFF);
    wr(8'h80, 8'hFF);
    periph_out.value[7] = 1'b1;
    periph_out.drive[7] = 1'b1;
    wr(8'hE1, 8'h04);
    wr(8'hE2, 8'h40);
    settle();
    cmp("two-wire data drive", 1'b0, pin_out.drive_en[0]);
    cmp("two-wire data level", 1'b1, pin_out.level[0]);
    cmp("push-pull neighbour", 1'b1, pin_out.drive_en[2]);
    wr(8'hE2, 8'h00);
    wr(8'h80, 8'h00);
    wr(8'hA0, 8'h00);
    settle();
    cmp("drive crossbar off", 25'h0F0_0000, pin_out.drive_en);
    wr(8'hC0, 8'h55);
    rd(8'hC0, 1'b0, 8'h00, "unmapped read");
    wr(8'hD6, 8'hFF);
    rd(8'hD6, 1'b0, 8'h0F, "port two skip");
    $display("test drivers done");
    do_reset();
    test_done();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    $display("BAD watchdog expected finish seen hang");
    test_done();
  end
endmodule
